// ---- rtl/brightness_tracker.sv ----
// Keeps the actuator's present brightness and polls it in passive feedback mode.
// Assumes feedback strobes come from same-clock bus front-end logic.
`timescale 1ns/1ps
`default_nettype none
module brightness_tracker
  import light_ctrl_pkg::*;
#(
  parameter int BRIGHT_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                passive,
  input  wire logic                refresh,
  input  wire logic                fb_valid,
  input  wire logic [BRIGHT_W-1:0] fb_value,
  output logic [BRIGHT_W-1:0]      bright_q,
  output logic                     known_q,
  output logic                     pend_q,
  output logic                     read_req_q
);

  logic [BRIGHT_W-1:0] bright_d;
  logic                known_d;
  logic                pend_d;
  logic                read_req_d;

  always_comb begin
    bright_d   = bright_q;
    known_d    = known_q;
    pend_d     = pend_q;
    read_req_d = 1'b0;
    if (refresh && passive) begin
      // The old value may be stale after a restart, so control waits for the answer.
      known_d    = 1'b0;
      pend_d     = 1'b1;
      read_req_d = 1'b1;
    end
    // An answer in the same cycle as a new refresh still counts for the new poll.
    if (fb_valid) begin
      bright_d = fb_value;
      known_d  = 1'b1;
      pend_d   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bright_q   <= '0;
      known_q    <= 1'b0;
      pend_q     <= 1'b0;
      read_req_q <= 1'b0;
    end else begin
      bright_q   <= bright_d;
      known_q    <= known_d;
      pend_q     <= pend_d;
      read_req_q <= read_req_d;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/constant_light_controller.sv ----
// Supervisor of the constant light controller: disabling state, restart handling,
// brightness feedback and a classic Wishbone register slave.
// Assumes restart and feedback strobes are one-cycle pulses on clk from the bus front end.
//
// Local design decisions: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module constant_light_controller
  import light_ctrl_pkg::*;
#(
  parameter int BRIGHT_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [31:0]         wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic                bus_return_evt,
  input  wire logic                download_evt,
  input  wire logic                manual_evt,
  input  wire logic [1:0]          fb1_return_policy,
  input  wire logic                fb1_download_disable,
  input  wire logic                fb_valid,
  input  wire logic [BRIGHT_W-1:0] fb_value,
  output logic                     read_req,
  output logic                     start_disable,
  output logic                     disabled,
  output logic                     control_enable,
  output logic [BRIGHT_W-1:0]      brightness
);

  // ==========================================================================
  // Elaboration checks
  // ==========================================================================
  // Field widths follow the package types, so the packing stays in step with them.
  localparam int RET_W           = $bits(return_policy_t);
  localparam int STATE_W         = $bits(dis_state_t);
  // Status packs brightness above the flag bits, so it must fit the data word.
  localparam int STAT_BRIGHT_OFS = STAT_STATE_OFS + STATE_W;

  if (BRIGHT_W < 1 || BRIGHT_W > 32 - STAT_BRIGHT_OFS) begin : g_bad_width
    $error("BRIGHT_W out of range");
  end

  // ==========================================================================
  // Address decode
  // ==========================================================================
  // Slot numbers of the four registers; unmapped addresses are caught by mapped().
  localparam logic [1:0] IDX_CTRL   = 2'h0;
  localparam logic [1:0] IDX_CMD    = 2'h1;
  localparam logic [1:0] IDX_STATUS = 2'h2;
  localparam logic [1:0] IDX_EVENTS = 2'h3;

  function automatic logic [1:0] decode(input logic [31:0] adr);
    logic [1:0] idx;
    idx = IDX_CTRL;
    if (adr[31:ADDR_W] != '0) begin
      idx = IDX_CTRL;
    end else if (adr[ADDR_W-1:0] == ADDR_CTRL) begin
      idx = IDX_CTRL;
    end else if (adr[ADDR_W-1:0] == ADDR_CMD) begin
      idx = IDX_CMD;
    end else if (adr[ADDR_W-1:0] == ADDR_STATUS) begin
      idx = IDX_STATUS;
    end else begin
      idx = IDX_EVENTS;
    end
    return idx;
  endfunction

  function automatic logic mapped(input logic [31:0] adr);
    return (adr[31:ADDR_W] == '0) &&
           ((adr[ADDR_W-1:0] == ADDR_CTRL) || (adr[ADDR_W-1:0] == ADDR_CMD) ||
            (adr[ADDR_W-1:0] == ADDR_STATUS) || (adr[ADDR_W-1:0] == ADDR_EVENTS));
  endfunction

  // ==========================================================================
  // Wishbone handshake
  // ==========================================================================
  logic        ack_q;
  logic        ack_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        req;
  logic        wr_take;
  logic [1:0]  sel_idx;
  logic        hit;

  assign req      = wb_cyc_i & wb_stb_i;
  assign sel_idx  = decode(wb_adr_i);
  assign hit      = mapped(wb_adr_i);
  // The write lands on the edge at which the master sees ack high.
  assign wr_take  = req & wb_we_i & ack_q & hit & wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ==========================================================================
  // Configuration register
  // ==========================================================================
  logic [CTRL_W-1:0] ctrl_q;
  logic [CTRL_W-1:0] ctrl_d;
  logic              passive;
  logic [1:0]        own_ret;
  logic              own_dl;
  logic              coupled;

  assign passive = ctrl_q[CTRL_PASSIVE_BIT];
  assign own_ret = ctrl_q[CTRL_RET_LSB +: RET_W];
  assign own_dl  = ctrl_q[CTRL_DL_BIT];
  assign coupled = ctrl_q[CTRL_COUPLED_BIT];

  always_comb begin
    ctrl_d = ctrl_q;
    if (wr_take && sel_idx == IDX_CTRL) begin
      ctrl_d = wb_dat_i[CTRL_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ==========================================================================
  // Restart decision
  // ==========================================================================
  logic restart_apply;
  logic restart_dis;
  logic was_disabled;

  restart_policy u_policy (
    .bus_return           (bus_return_evt),
    .download             (download_evt),
    .coupled              (coupled),
    .own_return_policy    (own_ret),
    .own_download_disable (own_dl),
    .fb1_return_policy    (fb1_return_policy),
    .fb1_download_disable (fb1_download_disable),
    .was_disabled         (was_disabled),
    .apply                (restart_apply),
    .go_disabled          (restart_dis)
  );

  // ==========================================================================
  // Disabling state machine
  // ==========================================================================
  // The state is not touched by restart events except through the policy, so it
  // carries the state held before the supply failed into the restore decision.
  dis_state_t state_q;
  dis_state_t state_d;
  logic       sw_disable;
  logic       sw_enable;

  // With both command bits set, the present state picks which one acts.
  assign sw_disable   = wr_take && sel_idx == IDX_CMD && wb_dat_i[CMD_DISABLE_BIT];
  assign sw_enable    = wr_take && sel_idx == IDX_CMD && wb_dat_i[CMD_ENABLE_BIT];
  assign was_disabled = state_q != ST_NORMAL;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL: begin
        if (sw_disable) begin
          state_d = ST_START_DIS;
        end
      end
      ST_START_DIS: begin
        state_d = ST_DISABLED;
      end
      ST_DISABLED: begin
        if (sw_enable) begin
          state_d = ST_NORMAL;
        end
      end
      default: begin
        state_d = ST_NORMAL;
      end
    endcase
    // A restart overrides any software command in the same cycle.
    if (restart_apply) begin
      if (restart_dis) begin
        state_d = ST_START_DIS;
      end else begin
        state_d = ST_NORMAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  assign start_disable = state_q == ST_START_DIS;
  assign disabled      = state_q != ST_NORMAL;

  // ==========================================================================
  // Brightness feedback
  // ==========================================================================
  logic known;
  logic pend;
  logic refresh;

  assign refresh = bus_return_evt | download_evt | manual_evt;

  brightness_tracker #(
    .BRIGHT_W (BRIGHT_W)
  ) u_track (
    .clk        (clk),
    .rst_n      (rst_n),
    .passive    (passive),
    .refresh    (refresh),
    .fb_valid   (fb_valid),
    .fb_value   (fb_value),
    .bright_q   (brightness),
    .known_q    (known),
    .pend_q     (pend),
    .read_req_q (read_req)
  );

  // Control may only compute outputs once the actuator brightness is held.
  assign control_enable = (state_q == ST_NORMAL) && known;

  // ==========================================================================
  // Sticky event flags, write one to clear, set wins
  // ==========================================================================
  logic [EVT_W-1:0] evt_q;
  logic [EVT_W-1:0] evt_d;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  always_comb begin
    evt_set                   = '0;
    evt_set[EVT_RETURN_BIT]   = bus_return_evt;
    evt_set[EVT_DOWNLOAD_BIT] = download_evt;
    evt_set[EVT_STARTDIS_BIT] = state_q == ST_START_DIS;
    evt_clr                   = '0;
    if (wr_take && sel_idx == IDX_EVENTS) begin
      evt_clr = wb_dat_i[EVT_W-1:0];
    end
    evt_d = (evt_q & ~evt_clr) | evt_set;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_q <= '0;
    end else begin
      evt_q <= evt_d;
    end
  end

  // ==========================================================================
  // Read data and acknowledge
  // ==========================================================================
  logic [31:0] status_word;

  always_comb begin
    status_word                                 = '0;
    status_word[STAT_KNOWN_OFS]                 = known;
    status_word[STAT_PEND_OFS]                  = pend;
    status_word[STAT_STATE_OFS +: STATE_W]      = state_q;
    status_word[STAT_BRIGHT_OFS +: BRIGHT_W]    = brightness;
  end

  always_comb begin
    // One wait state: ack follows the first cycle in which the request is seen.
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (ack_d) begin
      rdata_d = '0;
      if (!hit || wb_we_i) begin
        rdata_d = '0;
      end else if (sel_idx == IDX_CTRL) begin
        rdata_d[CTRL_W-1:0] = ctrl_q;
      end else if (sel_idx == IDX_STATUS) begin
        rdata_d = status_word;
      end else if (sel_idx == IDX_EVENTS) begin
        rdata_d[EVT_W-1:0] = evt_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule
`default_nettype wire

// ---- rtl/light_ctrl_pkg.sv ----
// Constants, register map and state types for the constant light controller supervisor.
// Assumes a classic Wishbone host and same-clock event strobes from the bus front end.
package light_ctrl_pkg;

  // ==========================================================================
  // Register map, byte addresses of aligned 32-bit words
  // ==========================================================================
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_CMD    = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam logic [3:0] ADDR_EVENTS = 4'hC;
  localparam int         ADDR_W      = 4;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int CTRL_PASSIVE_BIT  = 0;
  localparam int CTRL_RET_LSB      = 1;
  localparam int CTRL_DL_BIT       = 3;
  localparam int CTRL_COUPLED_BIT  = 4;
  localparam int CTRL_W            = 5;
  localparam int CMD_DISABLE_BIT   = 0;
  localparam int CMD_ENABLE_BIT    = 1;
  localparam int STAT_KNOWN_OFS    = 0;
  localparam int STAT_PEND_OFS     = 1;
  localparam int STAT_STATE_OFS    = 2;
  localparam int EVT_RETURN_BIT    = 0;
  localparam int EVT_DOWNLOAD_BIT  = 1;
  localparam int EVT_STARTDIS_BIT  = 2;
  localparam int EVT_W             = 3;

  localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;

  // ==========================================================================
  // Restart settings and disabling states
  // ==========================================================================
  typedef enum logic [1:0] {
    RET_NONE    = 2'b00,
    RET_DISABLE = 2'b01,
    RET_RESTORE = 2'b10
  } return_policy_t;

  typedef enum logic [1:0] {
    ST_NORMAL    = 2'b00,
    ST_START_DIS = 2'b01,
    ST_DISABLED  = 2'b10
  } dis_state_t;

endpackage

// ---- rtl/restart_policy.sv ----
// Combinational decision of the disabling state after a restart event.
// Assumes at most one of the two event strobes per cycle wins; bus return has priority.
`timescale 1ns/1ps
`default_nettype none
module restart_policy
  import light_ctrl_pkg::*;
(
  input  wire logic       bus_return,
  input  wire logic       download,
  input  wire logic       coupled,
  input  wire logic [1:0] own_return_policy,
  input  wire logic       own_download_disable,
  input  wire logic [1:0] fb1_return_policy,
  input  wire logic       fb1_download_disable,
  input  wire logic       was_disabled,
  output logic            apply,
  output logic            go_disabled
);

  logic [1:0] ret_pol;
  logic       dl_dis;

  always_comb begin
    // A reserved return code behaves as no reaction.
    ret_pol     = coupled ? fb1_return_policy : own_return_policy;
    dl_dis      = coupled ? fb1_download_disable : own_download_disable;
    apply       = bus_return | download;
    go_disabled = 1'b0;
    if (bus_return) begin
      if (ret_pol == RET_DISABLE) begin
        go_disabled = 1'b1;
      end else if (ret_pol == RET_RESTORE) begin
        go_disabled = was_disabled;
      end else begin
        go_disabled = 1'b0;
      end
    end else if (download) begin
      go_disabled = dl_dis;
    end
  end

endmodule
`default_nettype wire

// ---- tb/dim_actuator.sv ----
// Behavioural dimming actuator feeding back the brightness of its channel 1.
// Assumes read requests and level changes are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module dim_actuator #(
  parameter int BRIGHT_W = 8
) (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                read_req,
  input  wire logic                passive,
  input  wire logic [BRIGHT_W-1:0] level,
  input  wire logic [3:0]          delay,
  output logic                     fb_valid,
  output logic [BRIGHT_W-1:0]      fb_value
);
  // ==========================================================================
  // Feedback telegrams
  // ==========================================================================
  logic [BRIGHT_W-1:0] sent_q, sent_d, val_d;
  logic [4:0]          cnt_q, cnt_d;
  logic                send;

  // Outside a telegram the value line carries the inverse of the last value,
  // so a controller sampling it at the wrong time cannot read a lucky match.
  always_comb begin
    cnt_d = cnt_q;
    if (read_req && passive) begin
      cnt_d = {1'b0, delay} + 5'h1;
    end else if (cnt_q != 5'h0) begin
      cnt_d = cnt_q - 5'h1;
    end
    send = passive ? (cnt_q == 5'h1) : (level != sent_q);
    sent_d = send ? level : sent_q;
    val_d = send ? level : ~sent_d;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 5'h0;
      sent_q <= '0;
      fb_valid <= 1'b0;
      fb_value <= '1;
    end else begin
      cnt_q <= cnt_d;
      sent_q <= sent_d;
      fb_valid <= send;
      fb_value <= val_d;
    end
  end
endmodule
`default_nettype wire

// ---- tb/light_control_restart_policy_bench.sv ----
// Self-checking bench for the constant light controller supervisor.
// Assumes the package, the design, the checker and the actuator model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
  $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module light_control_restart_policy_bench
  import light_ctrl_pkg::*;
;
  typedef struct packed {
    logic       c;
    logic [1:0] oret;
    logic       odl;
    logic [1:0] fret;
    logic       fdl;
    // Spacer, so that event kind, prior state and result keep the low hex digit in the rows.
    logic       gap;
    logic       dl;
    logic       pre;
    logic       exp;
  } row_t;

  logic        clk = 1'b0, rst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o, q;
  logic        wb_ack_o, read_req, start_disable, disabled, control_enable, fb_valid;
  logic        bus_return_evt = 1'b0, download_evt = 1'b0, manual_evt = 1'b0;
  logic [1:0]  fb1_return_policy = 2'h0;
  logic        fb1_download_disable = 1'b0, act_passive = 1'b0;
  logic [7:0]  fb_value, brightness, level = 8'h00;
  int          fail_count = 0, tests_run = 0, rr_n = 0, sd_n = 0, n0;
  row_t        r;
  // Policy cases: own and motion-block settings, event kind, prior state, result.
  row_t        rows [13] = '{11'h000, 11'h101, 11'h203, 11'h200, 11'h002, 11'h004,
                             11'h085, 11'h500, 11'h421, 11'h443, 11'h484, 11'h415, 11'h300};

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    if (read_req === 1'b1) rr_n++;
    if (start_disable === 1'b1) sd_n++;
  end

  constant_light_controller dut_u (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i(4'hF), .wb_dat_i, .wb_dat_o, .wb_ack_o, .bus_return_evt, .download_evt,
    .manual_evt, .fb1_return_policy, .fb1_download_disable, .fb_valid, .fb_value, .read_req,
    .start_disable, .disabled, .control_enable, .brightness);

  dim_actuator act_u (.clk, .rst_n, .read_req, .passive(act_passive), .level,
    .delay(4'h6), .fb_valid, .fb_value);

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic print_verdict();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      fail_count++;
      $display("[FAIL] %0t bus acknowledge timeout", $time);
      print_verdict();
    end
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask

  task automatic pulse(input int k);
    bus_return_evt <= (k == 0);
    download_evt <= (k == 1);
    manual_evt <= (k == 2);
    @(posedge clk);
    bus_return_evt <= 1'b0;
    download_evt <= 1'b0;
    manual_evt <= 1'b0;
  endtask

  // The feedback answer time depends on the actuator, so the wait is bounded, not fixed.
  task automatic wait_ctl();
    int n;
    n = 0;
    while (control_enable !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    `CHK(control_enable, 1'b1)
    if (n >= 40) begin
      print_verdict();
    end
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(brightness, 8'h00)
    `CHK(control_enable, 1'b0)
    `CHK(disabled, 1'b0)
    rd(32'(ADDR_CTRL), 32'h0);
    rd(32'(ADDR_STATUS), 32'h0);
    rd(32'h10, 32'h0);
    for (int i = 0; i < 13; i++) begin
      r = rows[i];
      wb(1'b1, 32'(ADDR_CMD), 32'h2);
      wb(1'b1, 32'(ADDR_CTRL), {27'h0, r.c, r.odl, r.oret, 1'b0});
      fb1_return_policy <= r.fret;
      fb1_download_disable <= r.fdl;
      if (r.pre) begin
        wb(1'b1, 32'(ADDR_CMD), 32'h1);
        repeat (4) @(posedge clk);
      end
      n0 = sd_n;
      pulse(r.dl ? 1 : 0);
      repeat (4) @(posedge clk);
      `CHK(disabled, r.exp)
      `CHK(sd_n - n0, int'(r.exp))
    end
    rd(32'(ADDR_EVENTS), 32'h7);
    wb(1'b1, 32'(ADDR_EVENTS), 32'h7);
    rd(32'(ADDR_EVENTS), 32'h0);
    wb(1'b1, 32'(ADDR_CMD), 32'h2);
    wb(1'b1, 32'(ADDR_CTRL), 32'h0);
    level <= 8'h5A;
    wait_ctl();
    `CHK(brightness, 8'h5A)
    act_passive <= 1'b1;
    wb(1'b1, 32'(ADDR_CTRL), 32'h1);
    level <= 8'hA5;
    repeat (8) @(posedge clk);
    `CHK(brightness, 8'h5A)
    n0 = rr_n;
    pulse(2);
    @(posedge clk);
    `CHK(control_enable, 1'b0)
    rd(32'(ADDR_STATUS), 32'h5A2);
    wait_ctl();
    `CHK(brightness, 8'hA5)
    `CHK(rr_n - n0, 1)
    // A reset in mid-run must drop a held disabling state and the learned brightness.
    wb(1'b1, 32'(ADDR_CMD), 32'h1);
    `CHK(disabled, 1'b1)
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(disabled, 1'b0)
    `CHK(brightness, 8'h00)
    `CHK(control_enable, 1'b0)
    rd(32'(ADDR_CTRL), 32'h0);
    rd(32'(ADDR_STATUS), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- tb/light_ctrl_monitor.sv ----
// Checker for the constant light controller, fed from the top module's ports.
// Assumes one clock domain and at most one Wishbone request in flight.
`timescale 1ns/1ps
`default_nettype none
module light_ctrl_monitor #(
  parameter int BRIGHT_W = 8
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic                bus_return_evt,
  input wire logic                download_evt,
  input wire logic                manual_evt,
  input wire logic                fb_valid,
  input wire logic [BRIGHT_W-1:0] fb_value,
  input wire logic                read_req,
  input wire logic                start_disable,
  input wire logic                disabled,
  input wire logic                control_enable,
  input wire logic [BRIGHT_W-1:0] brightness
);
  // ==========================================================================
  // Properties
  // ==========================================================================
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_refresh;
    bus_return_evt || download_evt || manual_evt;
  endsequence
  sequence s_poll;
    s_refresh ##1 (read_req && !bus_return_evt && !download_evt && !manual_evt);
  endsequence

  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_fb_load;
    fb_valid |=> brightness == $past(fb_value);
  endproperty
  property p_hold;
    !fb_valid |=> $stable(brightness);
  endproperty
  property p_poll_cause;
    read_req |-> $past(bus_return_evt || download_evt || manual_evt);
  endproperty
  property p_poll_once;
    s_poll |=> !read_req;
  endproperty
  property p_poll_wait;
    read_req && !$past(fb_valid) |-> !control_enable;
  endproperty
  property p_known_ctl;
    fb_valid |=> control_enable == !disabled;
  endproperty
  property p_start_seq;
    $rose(disabled) |-> ##[0:2] start_disable;
  endproperty
  property p_start_dis;
    start_disable && !bus_return_evt && !download_evt |=> disabled && !start_disable;
  endproperty

  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_fb_load: assert property (p_fb_load) else $error("feedback not loaded");
  a_hold: assert property (p_hold) else $error("brightness changed alone");
  a_poll_cause: assert property (p_poll_cause) else $error("read without cause");
  a_poll_once: assert property (p_poll_once) else $error("read repeated");
  a_poll_wait: assert property (p_poll_wait) else $error("control during poll");
  a_known_ctl: assert property (p_known_ctl) else $error("control not released");
  a_start_seq: assert property (p_start_seq) else $error("no start behaviour");
  a_start_dis: assert property (p_start_dis) else $error("start not one cycle");
endmodule

bind constant_light_controller light_ctrl_monitor #(.BRIGHT_W(BRIGHT_W)) mon_u (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .bus_return_evt(bus_return_evt), .download_evt(download_evt),
  .manual_evt(manual_evt), .fb_valid(fb_valid), .fb_value(fb_value),
  .read_req(read_req), .start_disable(start_disable), .disabled(disabled),
  .control_enable(control_enable), .brightness(brightness));
`default_nettype wire
